//--- verilog/dsfc_pkg.sv
package dsfc_pkg;
    // ------------------------------------------------------------
    // bus geometry and register offsets
    // ------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam int WORD_W = 16;
    localparam logic [7:0] OFF_SFC = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_ECNT = 8'h08;
    localparam logic [7:0] OFF_GFR = 8'h0C;
    localparam logic [7:0] OFF_SRC = 8'h10;
    localparam logic [7:0] OFF_DST = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1C;

    // ------------------------------------------------------------
    // field positions, masks and reset values
    // ------------------------------------------------------------
    localparam int SYN_HI = 15;
    localparam int SYN_LO = 12;
    localparam int DOUBLE_WORD_ENABLE_BIT = 11;
    localparam int FC_HI = 7;
    localparam int AUTOINIT_BIT = 15;
    localparam int SIND_HI = 10;
    localparam int SIND_LO = 8;
    localparam int DMS_HI = 7;
    localparam int DMS_LO = 6;
    localparam int DIND_HI = 4;
    localparam int DIND_LO = 2;
    localparam int DMD_HI = 1;
    localparam int DMD_LO = 0;
    localparam logic [15:0] SFC_WMASK = 16'hF8FF;
    localparam logic [15:0] MODE_WMASK = 16'hF7DF;
    localparam logic [15:0] REG_RST = 16'h0000;

    // ------------------------------------------------------------
    // sync codes, index modes, event vector slots
    // ------------------------------------------------------------
    localparam logic [3:0] SYN_NONE = 4'h0;
    localparam logic [3:0] SYN_P0RX = 4'h1;
    localparam logic [3:0] SYN_P0TX = 4'h2;
    localparam logic [3:0] SYN_P1RX = 4'h5;
    localparam logic [3:0] SYN_P1TX = 4'h6;
    localparam logic [3:0] SYN_FIFORX = 4'h7;
    localparam logic [3:0] SYN_FIFOTX = 4'h8;
    localparam logic [3:0] SYN_TMR0 = 4'hD;
    localparam logic [3:0] SYN_XINT3 = 4'hE;
    localparam logic [3:0] SYN_TMR1 = 4'hF;
    localparam logic [2:0] IDX_NONE = 3'h0;
    localparam logic [2:0] IDX_DEC = 3'h2;
    localparam int EV_N = 9;
    localparam int EV_P0RX = 0;
    localparam int EV_P0TX = 1;
    localparam int EV_P1RX = 2;
    localparam int EV_P1TX = 3;
    localparam int EV_TMR0 = 4;
    localparam int EV_XINT3 = 5;
    localparam int EV_TMR1 = 6;
    localparam int EV_FIFORX = 7;
    localparam int EV_FIFOTX = 8;
endpackage

//--- verilog/dsfc_sync_if.sv
`timescale 1ns/1ps
// sync selection handshake between channel engine and selector
interface dsfc_sync_if;
    logic [3:0] code;
    logic take;
    logic pend;
    modport ctrl (output code, output take, input pend);
    modport sel (input code, input take, output pend);
endinterface

//--- verilog/dsfc_sync_sel.sv
`timescale 1ns/1ps
module dsfc_sync_sel
#(
    parameter bit FIFO_VARIANT = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [dsfc_pkg::EV_N-1:0] evts,
    dsfc_sync_if.sel s
);
    import dsfc_pkg::*;

    logic evt;
    logic valid;
    logic pend_q;
    logic [3:0] code_q;

    // ------------------------------------------------------------
    // code to event mapping
    // ------------------------------------------------------------
    // reserved codes give no event at all, so the channel stalls
    always_comb
    begin
        evt = 1'b0;
        valid = 1'b1;
        case (s.code)
            SYN_P0RX: evt = evts[EV_P0RX];
            SYN_P0TX: evt = evts[EV_P0TX];
            SYN_P1RX: evt = evts[EV_P1RX];
            SYN_P1TX: evt = evts[EV_P1TX];
            SYN_FIFORX: evt = FIFO_VARIANT & evts[EV_FIFORX];
            SYN_FIFOTX: evt = FIFO_VARIANT & evts[EV_FIFOTX];
            SYN_TMR0: evt = !FIFO_VARIANT & evts[EV_TMR0];
            SYN_XINT3: evt = !FIFO_VARIANT & evts[EV_XINT3];
            SYN_TMR1: evt = !FIFO_VARIANT & evts[EV_TMR1];
            default: valid = 1'b0;
        endcase
        if (s.code == SYN_NONE)
        begin
            valid = 1'b0;
        end
        if ((s.code == SYN_FIFORX || s.code == SYN_FIFOTX)
            && !FIFO_VARIANT)
        begin
            valid = 1'b0;
        end
        if (s.code >= SYN_TMR0 && FIFO_VARIANT)
        begin
            valid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pending event latch
    // ------------------------------------------------------------
    // a new event in the take cycle survives; a code change drops
    // any stale event caught for the previous source
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_q <= 1'b0;
            code_q <= SYN_NONE;
        end
        else if (ce)
        begin
            code_q <= s.code;
            if (code_q != s.code)
            begin
                pend_q <= evt;
            end
            else
            begin
                pend_q <= evt | (pend_q & ~s.take);
            end
        end
    end

    assign s.pend = pend_q & valid;
endmodule

//--- verilog/dsfc_chan.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - a synchronized channel waits for its selected event per element
// - sync code zero runs transfers back to back without waiting
// - exactly one event per element; single word moves 16 bits
// - double word: one event moves 32 bits as two 16-bit accesses
// - 4-bit sync select field, one source, resets to zero
// - code map: port0 rx/tx, port1 rx/tx, timer0, ext int 3, timer1
// - fifo variant: codes 7 and 8 select fifo rx/tx, 9..15 reserved
// - a double word counts as one element, halves handled in hardware
// - double word works with every address index mode
// - second half address is first address with bit 0 inverted
// - double word enable bit, reset clear meaning single word
// - 8-bit frame count holds frames minus one, up to 256 frames
// - frame count resets to zero, one frame per block
// - frame count decrements at the end of each frame but the last of the block
// - after last frame with autoinit, reload frame count from global
// - block length is element count times frame count, max 65536 elements times 256 frames
// - cpu write to frame count beats the controller update
// - 16-bit transfer mode register configures the channel
// - sync/frame layout: select 15:12, dword 11, rsvd 10:8, count 7:0
// - element counter decrements, reloads from shadow at frame end
module dsfc_chan
#(
    parameter bit FIFO_VARIANT = 1'b0
)
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [dsfc_pkg::APB_AW-1:0] PADDR,
    input wire logic [dsfc_pkg::APB_DW-1:0] PWDATA,
    output logic [dsfc_pkg::APB_DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PORT0_RX_EVT,
    input wire logic PORT0_TX_EVT,
    input wire logic PORT1_RX_EVT,
    input wire logic PORT1_TX_EVT,
    input wire logic TIMER0_EVT,
    input wire logic EXT_EXTERNAL_INTERRUPT_THREE_EVT,
    input wire logic TIMER1_EVT,
    input wire logic FIFO_RX_EVT,
    input wire logic FIFO_TX_EVT,
    input wire logic [dsfc_pkg::WORD_W-1:0] MEM_RDATA,
    output logic MEM_STB,
    output logic MEM_WE,
    output logic [dsfc_pkg::WORD_W-1:0] MEM_ADDR,
    output logic [1:0] MEM_SPACE,
    output logic [dsfc_pkg::WORD_W-1:0] MEM_WDATA,
    output logic BUSY
);
    import dsfc_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RD, S_WR} dsfc_state_e;

    dsfc_state_e st_q;
    logic [15:0] sfc_q;
    logic [15:0] mode_q;
    logic [15:0] shadow_q;
    logic [15:0] cnt_q;
    logic [15:0] gfr_q;
    logic [15:0] src_q;
    logic [15:0] dst_q;
    logic half_q;
    logic done_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic hit;
    logic acc;
    logic wr_en;
    logic go;
    logic elem_done;
    logic frame_end;
    logic blk_end;
    logic autoinit;
    logic double_word_enable;
    logic start;
    logic stop;
    logic [EV_N-1:0] evts;

    dsfc_sync_if sync ();

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // no wait state: read data is registered in setup so that
    // every top output comes from a flop
    assign acc = PSEL & PENABLE & pready_q;
    assign wr_en = acc & PWRITE;

    always_comb
    begin
        hit = 1'b1;
        rd_d = 32'h0000_0000;
        case (PADDR)
            OFF_SFC: rd_d[15:0] = sfc_q;
            OFF_MODE: rd_d[15:0] = mode_q;
            OFF_ECNT: rd_d[15:0] = cnt_q;
            OFF_GFR: rd_d[15:0] = gfr_q;
            OFF_SRC: rd_d[15:0] = src_q;
            OFF_DST: rd_d[15:0] = dst_q;
            OFF_CTRL: rd_d[0] = BUSY;
            OFF_STAT: rd_d[2:0] = {sync.pend, done_q, BUSY};
            default: hit = 1'b0;
        endcase
    end

    // setup phase captures read data and error, access completes
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else if (CE)
        begin
            pready_q <= PSEL & ~PENABLE;
            pslverr_q <= PSEL & ~PENABLE & ~hit;
            if (PSEL && !PENABLE && !PWRITE)
            begin
                prdata_q <= rd_d;
            end
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    assign autoinit = mode_q[AUTOINIT_BIT];
    assign double_word_enable = sfc_q[DOUBLE_WORD_ENABLE_BIT];
    assign start = wr_en && PADDR == OFF_CTRL && PWDATA[0];
    assign stop = wr_en && PADDR == OFF_CTRL && !PWDATA[0];
    assign sync.code = sfc_q[SYN_HI:SYN_LO];
    // code zero needs no event; others wait for a pending event
    assign go = (sync.code == SYN_NONE) | sync.pend;
    assign sync.take = CE && st_q == S_WAIT && go
        && sync.code != SYN_NONE;
    // the element ends after its last write, one per dword
    assign elem_done = CE && st_q == S_WR && !(double_word_enable && !half_q);
    assign frame_end = elem_done && cnt_q == 16'h0000;
    assign blk_end = frame_end && sfc_q[FC_HI:0] == 8'h00;

    assign evts[EV_P0RX] = PORT0_RX_EVT;
    assign evts[EV_P0TX] = PORT0_TX_EVT;
    assign evts[EV_P1RX] = PORT1_RX_EVT;
    assign evts[EV_P1TX] = PORT1_TX_EVT;
    assign evts[EV_TMR0] = TIMER0_EVT;
    assign evts[EV_XINT3] = EXT_EXTERNAL_INTERRUPT_THREE_EVT;
    assign evts[EV_TMR1] = TIMER1_EVT;
    assign evts[EV_FIFORX] = FIFO_RX_EVT;
    assign evts[EV_FIFOTX] = FIFO_TX_EVT;

    dsfc_sync_sel #(.FIFO_VARIANT(FIFO_VARIANT)) u_sel
    (
        .clk(MCLK),
        .rst_b(RST_B),
        .ce(CE),
        .evts(evts),
        .s(sync.sel)
    );

    // ------------------------------------------------------------
    // sync/frame and mode registers
    // ------------------------------------------------------------
    // cpu write has priority over the frame countdown and reload
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sfc_q <= REG_RST;
            mode_q <= REG_RST;
            gfr_q <= REG_RST;
        end
        else if (CE)
        begin
            if (wr_en && PADDR == OFF_MODE)
            begin
                mode_q <= PWDATA[15:0] & MODE_WMASK;
            end
            if (wr_en && PADDR == OFF_GFR)
            begin
                gfr_q <= PWDATA[15:0];
            end
            if (wr_en && PADDR == OFF_SFC)
            begin
                sfc_q <= PWDATA[15:0] & SFC_WMASK;
            end
            else if (blk_end && autoinit)
            begin
                sfc_q[FC_HI:0] <= gfr_q[FC_HI:0];
            end
            else if (frame_end && !blk_end)
            begin
                sfc_q[FC_HI:0] <= sfc_q[FC_HI:0] - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // element counter with shadow
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            shadow_q <= REG_RST;
            cnt_q <= REG_RST;
        end
        else if (CE)
        begin
            if (wr_en && PADDR == OFF_ECNT)
            begin
                shadow_q <= PWDATA[15:0];
                cnt_q <= PWDATA[15:0];
            end
            else if (frame_end)
            begin
                cnt_q <= shadow_q;
            end
            else if (elem_done)
            begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // address post-modification
    // ------------------------------------------------------------
    // steps by two in dword mode so the next pair is not overlapped;
    // index-register modes step like plain increment here
    function automatic logic [15:0] step(input logic [15:0] a,
                                         input logic [2:0] m,
                                         input logic dw);
        logic [15:0] d;
        d = dw ? 16'h0002 : 16'h0001;
        if (m == IDX_NONE)
        begin
            step = a;
        end
        else if (m == IDX_DEC)
        begin
            step = a - d;
        end
        else
        begin
            step = a + d;
        end
    endfunction

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            src_q <= REG_RST;
            dst_q <= REG_RST;
        end
        else if (CE)
        begin
            if (wr_en && PADDR == OFF_SRC)
            begin
                src_q <= PWDATA[15:0];
            end
            else if (elem_done)
            begin
                src_q <= step(src_q, mode_q[SIND_HI:SIND_LO], double_word_enable);
            end
            if (wr_en && PADDR == OFF_DST)
            begin
                dst_q <= PWDATA[15:0];
            end
            else if (elem_done)
            begin
                dst_q <= step(dst_q, mode_q[DIND_HI:DIND_LO], double_word_enable);
            end
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // each half is a read strobe then a write strobe one cycle apart
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_q <= S_IDLE;
            half_q <= 1'b0;
            done_q <= 1'b0;
            BUSY <= 1'b0;
            MEM_STB <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_ADDR <= REG_RST;
            MEM_SPACE <= 2'h0;
            MEM_WDATA <= REG_RST;
        end
        else if (CE)
        begin
            if (blk_end)
            begin
                done_q <= 1'b1;
            end
            else if (start)
            begin
                done_q <= 1'b0;
            end
            if (stop)
            begin
                st_q <= S_IDLE; // abort drops any half-done element
                half_q <= 1'b0;
                BUSY <= 1'b0;
                MEM_STB <= 1'b0;
                MEM_WE <= 1'b0;
            end
            else
            begin
                unique case (st_q)
                    S_IDLE:
                    begin
                        if (start)
                        begin
                            st_q <= S_WAIT;
                            BUSY <= 1'b1;
                        end
                    end
                    S_WAIT:
                    begin
                        if (go)
                        begin
                            st_q <= S_RD;
                            MEM_STB <= 1'b1;
                            MEM_WE <= 1'b0;
                            MEM_ADDR <= src_q;
                            MEM_SPACE <= mode_q[DMS_HI:DMS_LO];
                        end
                    end
                    S_RD:
                    begin
                        st_q <= S_WR;
                        MEM_WE <= 1'b1;
                        MEM_ADDR <= {dst_q[15:1], dst_q[0] ^ half_q};
                        MEM_SPACE <= mode_q[DMD_HI:DMD_LO];
                        MEM_WDATA <= MEM_RDATA;
                    end
                    S_WR:
                    begin
                        if (double_word_enable && !half_q)
                        begin
                            st_q <= S_RD;
                            half_q <= 1'b1;
                            MEM_WE <= 1'b0;
                            MEM_ADDR <= {src_q[15:1], ~src_q[0]};
                            MEM_SPACE <= mode_q[DMS_HI:DMS_LO];
                        end
                        else
                        begin
                            half_q <= 1'b0;
                            MEM_STB <= 1'b0;
                            MEM_WE <= 1'b0;
                            if (blk_end && !autoinit)
                            begin
                                st_q <= S_IDLE;
                                BUSY <= 1'b0;
                            end
                            else
                            begin
                                st_q <= S_WAIT;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    property p_hold;
        CE && !stop && st_q == S_WAIT && !go |=> st_q == S_WAIT;
    endproperty
    a_hold: assert property (p_hold)
        else $error("channel left wait without event");

    property p_free;
        CE && !stop && st_q == S_WAIT && sync.code == SYN_NONE
            |=> st_q == S_RD && MEM_STB && !MEM_WE;
    endproperty
    a_free: assert property (p_free)
        else $error("unsynchronized channel did not launch");

    property p_take;
        sync.take && !stop |=> st_q == S_RD && MEM_STB && !MEM_WE;
    endproperty
    a_take: assert property (p_take)
        else $error("event consumed outside launch");

    property p_dword;
        CE && !stop && st_q == S_WR && double_word_enable && !half_q
            |=> st_q == S_RD && half_q && !sync.take;
    endproperty
    a_dword: assert property (p_dword)
        else $error("second half of double word missing");

    property p_half_addr;
        st_q == S_RD && half_q && MEM_STB
            |-> MEM_ADDR == {src_q[15:1], ~src_q[0]};
    endproperty
    a_half_addr: assert property (p_half_addr)
        else $error("second half address wrong");

    property p_cpu_wins;
        CE && wr_en && PADDR == OFF_SFC
            |=> sfc_q[FC_HI:0] == $past(PWDATA[7:0]);
    endproperty
    a_cpu_wins: assert property (p_cpu_wins)
        else $error("frame count write lost");

    property p_fc_dec;
        frame_end && !blk_end && !(wr_en && PADDR == OFF_SFC)
            |=> sfc_q[FC_HI:0] == $past(sfc_q[FC_HI:0]) - 8'h01;
    endproperty
    a_fc_dec: assert property (p_fc_dec)
        else $error("frame count not decremented");

    property p_reload;
        blk_end && autoinit && !(wr_en && PADDR == OFF_SFC)
            |=> sfc_q[FC_HI:0] == $past(gfr_q[FC_HI:0]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("frame count not reloaded");

    property p_shadow;
        frame_end && !(wr_en && PADDR == OFF_ECNT)
            |=> cnt_q == $past(shadow_q);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("element count not reloaded");

    property p_reserved;
        sync.code inside {4'h3, 4'h4} |-> !sync.pend;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code produced event");

    c_sync: cover property (sync.take ##[1:3] st_q == S_WR);
    c_dword: cover property (st_q == S_RD && half_q);
    c_blk: cover property (blk_end && autoinit);
endmodule

//--- verif/dsfc_mem_model.sv
`timescale 1ns/1ps
// ------------------------
// far-side memory model
// ------------------------
module dsfc_mem_model
(
    input wire logic clk,
    input wire logic stb,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [1:0] space,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output int n_wr,
    output logic [15:0] wa,
    output logic [15:0] wd,
    output logic [1:0] ws
);
    initial n_wr = 0;
    // read data is an address pattern, valid in the strobe cycle
    // itself; off-strobe it shows the inverse so stale data fails
    assign rdata = (stb && !we) ? addr ^ 16'h5A5A : ~(addr ^ 16'h5A5A);
    always @(posedge clk)
    begin
        if (stb && we)
        begin
            n_wr <= n_wr + 1;
            wa <= addr;
            wd <= wdata;
            ws <= space;
        end
    end
endmodule

//--- verif/dsfc_chan_tb.sv
`timescale 1ns/1ps
module dsfc_chan_tb;
    import dsfc_pkg::*;
    logic MCLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, CE = 1;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r;
    logic PREADY, PSLVERR, STB, WE, BUSY, e;
    logic [8:0] ev = 9'h000;
    logic [15:0] RD, ADDR, WDATA, wa, wd, fa;
    logic [1:0] SPACE, ws;
    int n_mismatch = 0, comparisons = 0, n_wr, w0;
    logic [3:0] codes [7] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'hD, 4'hE, 4'hF};
    int evs [7] = '{EV_P0RX, EV_P0TX, EV_P1RX, EV_P1TX, EV_TMR0,
        EV_XINT3, EV_TMR1};
    // 100 ns clock
    always #50 MCLK = ~MCLK;
    dsfc_chan i_dsfc_chan (.MCLK(MCLK), .RST_B(RST_B), .CE(CE),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PORT0_RX_EVT(ev[EV_P0RX]),
        .PORT0_TX_EVT(ev[EV_P0TX]), .PORT1_RX_EVT(ev[EV_P1RX]),
        .PORT1_TX_EVT(ev[EV_P1TX]), .TIMER0_EVT(ev[EV_TMR0]),
        .EXT_EXTERNAL_INTERRUPT_THREE_EVT(ev[EV_XINT3]), .TIMER1_EVT(ev[EV_TMR1]),
        .FIFO_RX_EVT(ev[EV_FIFORX]), .FIFO_TX_EVT(ev[EV_FIFOTX]),
        .MEM_RDATA(RD), .MEM_STB(STB), .MEM_WE(WE), .MEM_ADDR(ADDR),
        .MEM_SPACE(SPACE), .MEM_WDATA(WDATA), .BUSY(BUSY));
    dsfc_mem_model i_dsfc_mem_model (.clk(MCLK), .stb(STB), .we(WE),
        .addr(ADDR), .space(SPACE), .wdata(WDATA), .rdata(RD),
        .n_wr(n_wr), .wa(wa), .wd(wd), .ws(ws));
    // ------------------------
    // bus and check tasks
    // ------------------------
    task automatic chk(input string s, input logic [31:0] v,
        input logic [31:0] x);
        comparisons++;
        if (v !== x)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", s, x, v);
        end
    endtask
    // one apb transfer; idle edge first so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge MCLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {16'h0000, d};
        @(posedge MCLK);
        PENABLE <= 1;
        do
        begin
            @(posedge MCLK);
        end
        while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge MCLK);
        ev <= m;
        @(posedge MCLK);
        ev <= 9'h000;
    endtask
    // no own limit: only the watchdog ends a hung wait
    task automatic wait_idle();
        do
        begin
            @(posedge MCLK);
        end
        while (BUSY !== 1'b0);
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: whole run needs far fewer cycles
    initial
    begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        summarize();
    end
    // ------------------------
    // main sequence
    // ------------------------
    initial
    begin
        repeat (10) @(posedge MCLK);
        RST_B <= 1;
        apb(0, OFF_SFC, 0);
        chk("sfc reset", r, 0);
        apb(0, OFF_MODE, 0);
        chk("mode reset", r, 0);
        apb(1, OFF_SFC, 16'hFFFF);
        apb(0, OFF_SFC, 0);
        chk("sfc mask", r, 32'h0000_F8FF);
        apb(0, 8'h20, 0);
        chk("unmapped err", e, 1);
        // unsync, two frames of two elements, both addresses step up
        apb(1, OFF_SFC, 16'h0001);
        apb(1, OFF_ECNT, 16'h0001);
        apb(1, OFF_MODE, 16'h0146);
        apb(1, OFF_SRC, 16'h0010);
        apb(1, OFF_DST, 16'h0100);
        w0 = n_wr;
        apb(1, OFF_CTRL, 16'h0001);
        wait_idle();
        chk("block writes", n_wr - w0, 4);
        chk("last dst", wa, 16'h0103);
        chk("last data", wd, 16'h0013 ^ 16'h5A5A);
        chk("last space", ws, 2'h2);
        apb(1, OFF_MODE, 16'h0000);
        // each code answers only to its own event
        for (int i = 0; i < 7; i++)
        begin
            apb(1, OFF_SFC, {codes[i], 12'h000});
            apb(1, OFF_ECNT, 16'h0000);
            w0 = n_wr;
            apb(1, OFF_CTRL, 16'h0001);
            pulse(9'h1FF & ~(9'h001 << evs[i]));
            repeat (8) @(posedge MCLK);
            chk("held write", n_wr, w0);
            pulse(9'h001 << evs[i]);
            wait_idle();
            chk("one element", n_wr, w0 + 1);
        end
        // double word on timer 0, odd source and even destination
        apb(1, OFF_SFC, 16'hD800);
        apb(1, OFF_SRC, 16'h0021);
        apb(1, OFF_DST, 16'h0040);
        w0 = n_wr;
        apb(1, OFF_CTRL, 16'h0001);
        pulse(9'h001 << EV_TMR0);
        wait_idle();
        chk("dword writes", n_wr, w0 + 2);
        chk("dword addr", wa, 16'h0041);
        chk("dword data", wd, 16'h0020 ^ 16'h5A5A);
        // reserved codes 3 and 7, fifo rx code included, never launch
        for (int c = 3; c < 8; c += 4)
        begin
            apb(1, OFF_SFC, {c[3:0], 12'h000});
            w0 = n_wr;
            apb(1, OFF_CTRL, 16'h0001);
            pulse(9'h1FF);
            repeat (8) @(posedge MCLK);
            chk("reserved code", n_wr, w0);
            apb(1, OFF_CTRL, 16'h0000);
            wait_idle();
        end
        // autoinit keeps the channel running past the block end
        apb(1, OFF_SFC, 16'h0000);
        apb(1, OFF_GFR, 16'h0003);
        apb(1, OFF_MODE, 16'h8000);
        apb(1, OFF_CTRL, 16'h0001);
        repeat (20) @(posedge MCLK);
        chk("autoinit busy", BUSY, 1);
        // clock enable low must freeze the running channel
        CE <= 0;
        @(posedge MCLK);
        fa = ADDR;
        repeat (6) @(posedge MCLK);
        chk("frozen addr", ADDR, fa);
        CE <= 1;
        apb(1, OFF_CTRL, 16'h0000);
        wait_idle();
        chk("stopped", BUSY, 0);
        summarize();
    end
endmodule
